// [rtl/port_err_pkg.sv]
// Constants for the per-port interrupt and error status block.
package port_err_pkg;

    // Register byte offsets on the Avalon-MM slave.
    localparam logic [4:0] OFF_STATUS  = 5'h00;
    localparam logic [4:0] OFF_FORCE   = 5'h04;
    localparam logic [4:0] OFF_ENABLE  = 5'h08;
    localparam logic [4:0] OFF_THRESH  = 5'h0c;
    localparam logic [4:0] OFF_COUNT   = 5'h10;

    // Status bits live in the top byte; index i is register bit 24 + i.
    localparam int FLAG_BASE = 24;
    localparam int FLAG_W    = 8;
    localparam int F_ILLEGAL = 0;
    localparam int F_SUMMARY = 1;
    localparam int F_RETRY   = 2;
    localparam int F_OUTBND  = 3;
    localparam int F_INBND   = 4;
    localparam int F_REORDER = 5;
    localparam int F_RSVD    = 6;
    localparam int F_TIMEOUT = 7;

    // Flags that hardware may set and software may clear.
    localparam logic [7:0] FLAG_RW_MASK = 8'hbd;
    // Flags that feed the summary error flag.
    localparam logic [7:0] ERROR_MASK   = 8'hbd;
    // Flags also cleared when the error detect register is emptied.
    localparam logic [7:0] DETECT_MASK  = 8'h84;

    // Enable register: bits 24..29 and 31 gate interrupts, bit 0 the retry
    // port-write.
    localparam int EN_RETRY_PW = 0;
    localparam logic [31:0] ENABLE_MASK = 32'hbf000001;

    // Counter slots, eight bits each in the threshold and count registers.
    localparam int CNT_W      = 8;
    localparam int NCNT       = 4;
    localparam int C_RETRY    = 0;
    localparam int C_OUTBND   = 1;
    localparam int C_INBND    = 2;
    localparam int C_REORDER  = 3;
    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [7:0] CNT_ONE  = 8'h01;
    localparam logic [7:0] CNT_MAX  = 8'hff;

    localparam logic [31:0] RESET_WORD = 32'h00000000;

endpackage

// [rtl/port_error_interrupt_status.sv]
// Per-port interrupt and error status flags with an Avalon-MM slave.
`timescale 1ns/1ps

// Summary of operation
// - Reserved transport type sets illegal flag, except maintenance hop zero.
// - Unmapped destination identifier sets illegal flag.
// - Illegal flag holds until written one.
// - Enabled illegal flag raises port-write and interrupt.
// - Illegal port-write immediate; also report error detect.
// - Summary flag reads while any error remains.
// - Summary flag interrupts only when enabled.
// - Retry count reaching threshold sets retry flag.
// - Retry flag interrupt and port-write each need own enable.
// - Retry flag ignored when threshold is zero.
// - Retry flag clears by write or detect clear.
// - Outbound depth count reaching threshold sets flag.
// - Depth and reorder interrupts need own enable.
// - Writing one clears outbound flag and congestion counter.
// - Inbound depth count reaching threshold sets flag.
// - Writing one clears inbound flag and counter.
// - Reordering count reaching threshold sets flag.
// - Writing one clears reordering flag and counter.
// - Fabric timeout sets flag; write or detect clears.
// - Force register zero bit clears status flag.
module port_error_interrupt_status (
    input  wire logic        clk,
    input  wire logic        resetn,
    // Avalon-MM slave.
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [3:0]  byteenable,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // Receive-side packet check, one cycle per received packet.
    input  wire logic        rx_pkt_valid,
    input  wire logic        rx_tt_reserved,
    input  wire logic        rx_maintenance,
    input  wire logic        rx_hop_zero,
    input  wire logic        rx_dest_unmapped,
    // Event pulses: the first four advance the threshold counters; then fabric timeout and detect clear.
    input  wire logic        retry_event,
    input  wire logic        outbound_congest_event,
    input  wire logic        inbound_queue_event,
    input  wire logic        reorder_event,
    input  wire logic        fabric_timeout_event,
    input  wire logic        error_detect_cleared,
    // Results.
    output logic             irq,
    output logic             port_write_req,
    output logic             error_detect_illegal
);

    // ---------------------------------------------------------------
    // Bus slave: one wait cycle on every access, answer on the second
    // edge. The extra cycle lets read data come from a flop.
    // ---------------------------------------------------------------
    logic        ack_q;
    logic        ack_d;
    logic [31:0] readdata_q;
    logic [31:0] readdata_d;

    wire logic        req      = read | write;
    wire logic        take     = req & ack_q;
    wire logic        wr_take  = write & ack_q;
    wire logic [31:0] be_mask  = {{8{byteenable[3]}}, {8{byteenable[2]}},
                                  {8{byteenable[1]}}, {8{byteenable[0]}}};
    wire logic [31:0] wdata_be = writedata & be_mask;

    wire logic sel_status = (address == port_err_pkg::OFF_STATUS);
    wire logic sel_force  = (address == port_err_pkg::OFF_FORCE);
    wire logic sel_enable = (address == port_err_pkg::OFF_ENABLE);
    wire logic sel_thresh = (address == port_err_pkg::OFF_THRESH);
    wire logic sel_count  = (address == port_err_pkg::OFF_COUNT);

    assign ack_d       = req & ~ack_q;
    assign waitrequest = req & ~ack_q;
    assign readdata    = readdata_q;

    // ---------------------------------------------------------------
    // Software registers.
    // ---------------------------------------------------------------
    logic [31:0] enable_q;
    logic [31:0] enable_d;
    logic [31:0] thresh_q;
    logic [31:0] thresh_d;

    assign enable_d = (wr_take & sel_enable)
        ? (((enable_q & ~be_mask) | wdata_be)
           & port_err_pkg::ENABLE_MASK)
        : enable_q;
    assign thresh_d = (wr_take & sel_thresh)
        ? ((thresh_q & ~be_mask) | wdata_be) : thresh_q;

    wire logic [7:0] en_flags = enable_q[port_err_pkg::FLAG_BASE +:
                                         port_err_pkg::FLAG_W];
    wire logic retry_pw_en = enable_q[port_err_pkg::EN_RETRY_PW];

    // Top-byte write data, only when that byte lane is enabled.
    wire logic [7:0] top_wdata = writedata[port_err_pkg::FLAG_BASE +:
                                           port_err_pkg::FLAG_W];
    wire logic       top_lane  = byteenable[3];

    // Write-one-to-clear on the status register.
    wire logic [7:0] w1c = (wr_take & sel_status & top_lane)
        ? top_wdata : 8'h00;
    // Force register: ones set, zeros clear.
    wire logic [7:0] force_set = (wr_take & sel_force & top_lane)
        ? top_wdata : 8'h00;
    wire logic [7:0] force_clr = (wr_take & sel_force & top_lane)
        ? ~top_wdata : 8'h00;
    wire logic [7:0] detect_clr = error_detect_cleared
        ? port_err_pkg::DETECT_MASK : 8'h00;

    // ---------------------------------------------------------------
    // Threshold counters: retry, outbound congestion, inbound queue
    // depth and reordering. Each saturates rather than wraps, so a
    // flag cleared late does not re-fire on a wrapped count.
    // ---------------------------------------------------------------
    localparam int CW = port_err_pkg::CNT_W;
    localparam int NC = port_err_pkg::NCNT;

    logic [CW-1:0] cnt_q [NC];
    logic [CW-1:0] cnt_d [NC];
    logic [NC-1:0] cnt_hit;
    logic [NC-1:0] cnt_clr;

    wire logic [NC-1:0] cnt_inc = {reorder_event, inbound_queue_event,
                                   outbound_congest_event, retry_event};

    // Writing one to a counted flag also empties its counter.
    assign cnt_clr[port_err_pkg::C_RETRY] =
        w1c[port_err_pkg::F_RETRY] | detect_clr[port_err_pkg::F_RETRY];
    assign cnt_clr[port_err_pkg::C_OUTBND] =
        w1c[port_err_pkg::F_OUTBND];
    assign cnt_clr[port_err_pkg::C_INBND] =
        w1c[port_err_pkg::F_INBND];
    assign cnt_clr[port_err_pkg::C_REORDER] =
        w1c[port_err_pkg::F_REORDER];

    for (genvar i = 0; i < NC; i++) begin : g_cnt
        wire logic [CW-1:0] thr = thresh_q[i*CW +: CW];
        wire logic [CW-1:0] nxt = (cnt_q[i] == port_err_pkg::CNT_MAX)
            ? cnt_q[i] : cnt_q[i] + port_err_pkg::CNT_ONE;

        always_comb begin
            if (cnt_clr[i]) begin
                cnt_d[i] = port_err_pkg::CNT_ZERO;
            end else if (cnt_inc[i]) begin
                cnt_d[i] = nxt;
            end else begin
                cnt_d[i] = cnt_q[i];
            end
        end

        // A zero threshold never fires.
        assign cnt_hit[i] = cnt_inc[i] & ~cnt_clr[i]
            & (thr != port_err_pkg::CNT_ZERO)
            & (nxt == thr) & (cnt_q[i] != thr);

        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                cnt_q[i] <= port_err_pkg::CNT_ZERO;
            end else begin
                cnt_q[i] <= cnt_d[i];
            end
        end
    end

    // ---------------------------------------------------------------
    // Status flags.
    // ---------------------------------------------------------------
    logic [7:0] flags_q;
    logic [7:0] flags_d;
    logic [7:0] hw_set;

    // Maintenance packets with hop count zero may use the reserved type.
    wire logic illegal_tt = rx_tt_reserved
        & ~(rx_maintenance & rx_hop_zero);
    wire logic illegal_hit = rx_pkt_valid
        & (illegal_tt | rx_dest_unmapped);

    always_comb begin
        hw_set = 8'h00;
        hw_set[port_err_pkg::F_ILLEGAL] = illegal_hit;
        hw_set[port_err_pkg::F_RETRY] =
            cnt_hit[port_err_pkg::C_RETRY];
        hw_set[port_err_pkg::F_OUTBND] =
            cnt_hit[port_err_pkg::C_OUTBND];
        hw_set[port_err_pkg::F_INBND] =
            cnt_hit[port_err_pkg::C_INBND];
        hw_set[port_err_pkg::F_REORDER] =
            cnt_hit[port_err_pkg::C_REORDER];
        hw_set[port_err_pkg::F_TIMEOUT] =
            fabric_timeout_event;
    end

    // Setting wins over a clear arriving in the same cycle, except on the four
    // counted flags, where a counter clear suppresses the hit and the event is lost.
    wire logic [7:0] any_set = (hw_set | force_set)
        & port_err_pkg::FLAG_RW_MASK;
    wire logic [7:0] any_clr = w1c | force_clr
        | detect_clr;

    assign flags_d = (any_set | (flags_q & ~any_clr))
        & port_err_pkg::FLAG_RW_MASK;

    // Summary reads set while any error flag is still standing.
    wire logic summary = |(flags_q
        & port_err_pkg::ERROR_MASK);

    wire logic [7:0] status_view = flags_q
        | (summary ? (8'h01 << port_err_pkg::F_SUMMARY) : 8'h00);

    // ---------------------------------------------------------------
    // Interrupt and port-write generation.
    // ---------------------------------------------------------------
    wire logic [7:0] rising = flags_d & ~flags_q;

    // Each flag interrupts only under its own enable bit.
    wire logic irq_d = |(status_view & en_flags
        & port_err_pkg::FLAG_RW_MASK)
        | (summary & en_flags[port_err_pkg::F_SUMMARY]);

    // Illegal transfers report at once, not through a rate threshold.
    wire logic pw_d =
        (rising[port_err_pkg::F_ILLEGAL]
         & en_flags[port_err_pkg::F_ILLEGAL])
        | (rising[port_err_pkg::F_RETRY] & retry_pw_en);

    wire logic det_d = illegal_hit;

    // ---------------------------------------------------------------
    // Read mux.
    // ---------------------------------------------------------------
    logic [31:0] count_word;
    always_comb begin
        count_word = port_err_pkg::RESET_WORD;
        for (int k = 0; k < NC; k++) begin
            count_word[k*CW +: CW] = cnt_q[k];
        end
    end

    wire logic [31:0] status_word = {status_view, 24'h000000};

    always_comb begin
        if (!(read & ~ack_q)) begin
            readdata_d = readdata_q;
        end else if (sel_status) begin
            readdata_d = status_word;
        end else if (sel_enable) begin
            readdata_d = enable_q;
        end else if (sel_thresh) begin
            readdata_d = thresh_q;
        end else if (sel_count) begin
            readdata_d = count_word;
        end else begin
            // Force register and unmapped addresses read as zero.
            readdata_d = port_err_pkg::RESET_WORD;
        end
    end

    // ---------------------------------------------------------------
    // State.
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ack_q      <= 1'b0;
            readdata_q <= port_err_pkg::RESET_WORD;
            enable_q   <= port_err_pkg::RESET_WORD;
            thresh_q   <= port_err_pkg::RESET_WORD;
        end else begin
            ack_q      <= ack_d;
            readdata_q <= readdata_d;
            enable_q   <= enable_d;
            thresh_q   <= thresh_d;
        end
    end

    logic irq_q;
    logic pw_q;
    logic det_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flags_q <= 8'h00;
            irq_q   <= 1'b0;
            pw_q    <= 1'b0;
            det_q   <= 1'b0;
        end else begin
            flags_q <= flags_d;
            irq_q   <= irq_d;
            pw_q    <= pw_d;
            det_q   <= det_d;
        end
    end

    assign irq                  = irq_q;
    assign port_write_req       = pw_q;
    assign error_detect_illegal = det_q;

    // Unused low write data on the status and force registers is
    // deliberately dropped; only the top byte holds flags.

endmodule // port_error_interrupt_status

// [sim/port_error_interrupt_status_sva.sv]
// Concurrent checks on the ports of the port error status block.
`timescale 1ns/1ps
module port_error_interrupt_status_sva (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic [4:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        rx_pkt_valid,
    input wire logic        rx_tt_reserved,
    input wire logic        rx_maintenance,
    input wire logic        rx_hop_zero,
    input wire logic        rx_dest_unmapped,
    input wire logic        irq,
    input wire logic        port_write_req,
    input wire logic        error_detect_illegal
);
    logic [31:0] en_q;
    wire logic        acc = write && !waitrequest;
    wire logic [31:0] en_d = (acc && address == port_err_pkg::OFF_ENABLE)
                             ? writedata : en_q;
    // A forced illegal flag may report like a detected one.
    wire logic        bad = (rx_pkt_valid && (rx_dest_unmapped
        || (rx_tt_reserved && !(rx_maintenance && rx_hop_zero))))
        || (acc && address == port_err_pkg::OFF_FORCE && writedata[24]);
    wire logic        pw_en = en_q[24] || en_q[0];
    wire logic        irq_en = |en_q[31:24];
    wire logic        st_rd = read && !waitrequest
                              && address == port_err_pkg::OFF_STATUS;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) en_q <= 32'h00000000;
        else en_q <= en_d;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    wait_one_a: assert property ($rose(read || write) |->
        waitrequest ##1 !waitrequest) else $error("bus wait not one cycle");
    det_tt_a: assert property (rx_pkt_valid && rx_tt_reserved &&
        !(rx_maintenance && rx_hop_zero) |-> ##[1:2] error_detect_illegal)
        else $error("reserved type missed");
    det_exempt_a: assert property (rx_pkt_valid &&
        rx_tt_reserved && rx_maintenance && rx_hop_zero && !rx_dest_unmapped
        |=> !error_detect_illegal) else $error("hop zero reported");
    det_unmap_a: assert property (rx_pkt_valid && rx_dest_unmapped
        |-> ##[1:2] error_detect_illegal) else $error("unmapped missed");
    det_cause_a: assert property (error_detect_illegal |->
        $past(bad) || $past(bad, 2)) else $error("detect without cause");
    pw_ill_a: assert property (bad && en_q[24] |->
        ##[1:2] port_write_req) else $error("illegal port-write missed");
    pw_gate_a: assert property (port_write_req |->
        $past(pw_en) || $past(pw_en, 2)) else $error("port-write not enabled");
    irq_gate_a: assert property (irq |-> $past(irq_en) ||
        $past(irq_en, 2) || $past(irq_en, 3)) else $error("irq not enabled");
    summary_a: assert property (st_rd |-> readdata[25] ==
        |(readdata[31:24] & port_err_pkg::ERROR_MASK)) else $error("summary");

    cover property (port_write_req);
    cover property (irq);
    cover property (st_rd && readdata[25]);
endmodule // port_error_interrupt_status_sva

bind port_error_interrupt_status port_error_interrupt_status_sva sva_inst (
    .clk, .resetn, .address, .read, .write, .writedata, .readdata,
    .waitrequest, .rx_pkt_valid, .rx_tt_reserved, .rx_maintenance,
    .rx_hop_zero, .rx_dest_unmapped, .irq, .port_write_req,
    .error_detect_illegal);

// [sim/port_error_interrupt_status_tb_top.sv]
// Self-checking bench for the port error and interrupt status block.
`timescale 1ns/1ps
module port_error_interrupt_status_tb_top;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic        waitrequest, irq, port_write_req, error_detect_illegal;
    logic [3:0]  byteenable = 4'hf;
    logic [4:0]  address = 5'h00;
    logic [4:0]  rx = 5'h00;
    logic [5:0]  ev = 6'h00;
    logic [31:0] writedata = 32'h00000000;
    logic [31:0] readdata, d;
    int          num_errors = 0, n_tests = 0, pw_cnt = 0, det_cnt = 0;

    // Rx is valid, tt reserved, maintenance, hop zero, unmapped; ev is
    // retry, outbound, inbound, reorder, timeout, detect cleared.
    port_error_interrupt_status port_error_interrupt_status_inst (
        .clk, .resetn, .address, .read, .write, .byteenable, .writedata,
        .readdata, .waitrequest, .rx_pkt_valid(rx[4]),
        .rx_tt_reserved(rx[3]), .rx_maintenance(rx[2]),
        .rx_hop_zero(rx[1]), .rx_dest_unmapped(rx[0]),
        .retry_event(ev[0]), .outbound_congest_event(ev[1]),
        .inbound_queue_event(ev[2]), .reorder_event(ev[3]),
        .fabric_timeout_event(ev[4]), .error_detect_cleared(ev[5]),
        .irq, .port_write_req, .error_detect_illegal);

    initial begin
        forever #5 clk = ~clk;
    end

    always @(negedge clk) begin
        pw_cnt += int'(port_write_req === 1'b1);
        det_cnt += int'(error_detect_illegal === 1'b1);
    end

    task automatic check(input string n, input logic [31:0] s, e);
        n_tests++;
        if (s !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    // The request stands until waitrequest is seen low at a rising edge,
    // and the read data are taken at that same edge; one idle edge
    // follows so that a new request never lands in the release step.
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] v);
        address <= a;
        writedata <= v;
        read <= ~w;
        write <= w;
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        d = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input string n, input logic [4:0] a,
                      input logic [31:0] e);
        bus(1'b0, a, 32'h00000000);
        check(n, d, e);
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        bus(1'b1, a, v);
    endtask

    task automatic pulse(input logic [4:0] r, input logic [5:0] e,
                         input int n);
        repeat (n) begin
            rx <= r;
            ev <= e;
            @(posedge clk);
            rx <= 5'h00;
            ev <= 6'h00;
            @(posedge clk);
        end
    endtask

    // Irq is registered behind the flags, so it is given a few edges.
    task automatic irq_is(input logic e);
        repeat (3) @(posedge clk);
        @(negedge clk);
        check("irq", 32'(irq), 32'(e));
        @(posedge clk);
    endtask

    task automatic t_reset;
        for (int a = 0; a <= 20; a += 4) begin
            rd("reset", 5'(a), 32'h00000000);
        end
    endtask

    task automatic t_illegal;
        wr(5'h08, 32'h01000000);
        pulse(5'h1e, 6'h00, 1);
        rd("hop0", 5'h00, 32'h00000000);
        pulse(5'h1c, 6'h00, 1);
        rd("tt", 5'h00, 32'h03000000);
        check("det", 32'(det_cnt), 32'h00000001);
        check("pw", 32'(pw_cnt), 32'h00000001);
        irq_is(1'b1);
        wr(5'h00, 32'h00000000);
        rd("hold", 5'h00, 32'h03000000);
        wr(5'h00, 32'h01000000);
        rd("w1c", 5'h00, 32'h00000000);
        irq_is(1'b0);
        pulse(5'h11, 6'h00, 1);
        rd("unmap", 5'h00, 32'h03000000);
        check("pw2", 32'(pw_cnt), 32'h00000002);
        check("det2", 32'(det_cnt), 32'h00000002);
        wr(5'h00, 32'h01000000);
    endtask

    task automatic t_depth;
        wr(5'h0c, 32'h02010300);
        pulse(5'h00, 6'h0e, 1);
        rd("inb", 5'h00, 32'h12000000);
        pulse(5'h00, 6'h0a, 1);
        rd("rdr", 5'h00, 32'h32000000);
        rd("cnt", 5'h10, 32'h02010200);
        pulse(5'h00, 6'h02, 1);
        rd("outb", 5'h00, 32'h3a000000);
        wr(5'h00, 32'h08000000);
        rd("cong", 5'h10, 32'h02010000);
        wr(5'h00, 32'h30000000);
        rd("cclr", 5'h10, 32'h00000000);
        rd("sclr", 5'h00, 32'h00000000);
    endtask

    task automatic t_retry;
        wr(5'h0c, 32'h00000000);
        pulse(5'h00, 6'h01, 2);
        rd("thr0", 5'h00, 32'h00000000);
        pulse(5'h00, 6'h20, 1);
        wr(5'h0c, 32'h00000002);
        wr(5'h08, 32'h04000001);
        pulse(5'h00, 6'h01, 1);
        rd("rt1", 5'h00, 32'h00000000);
        pulse(5'h00, 6'h01, 1);
        rd("rt2", 5'h00, 32'h06000000);
        check("rtpw", 32'(pw_cnt), 32'h00000003);
        irq_is(1'b1);
        pulse(5'h00, 6'h10, 1);
        rd("tmo", 5'h00, 32'h86000000);
        pulse(5'h00, 6'h20, 1);
        rd("edc", 5'h00, 32'h00000000);
        pulse(5'h00, 6'h01, 2);
        wr(5'h00, 32'h04000000);
        rd("rtw1c", 5'h00, 32'h00000000);
        wr(5'h04, 32'hbd000000);
        rd("force", 5'h00, 32'hbf000000);
        wr(5'h04, 32'h00000000);
        rd("unforce", 5'h00, 32'h00000000);
    endtask

    task automatic t_irq;
        wr(5'h08, 32'h08000000);
        wr(5'h04, 32'h10000000);
        irq_is(1'b0);
        wr(5'h08, 32'h10000000);
        irq_is(1'b1);
        wr(5'h08, 32'h02000000);
        irq_is(1'b1);
        wr(5'h04, 32'h00000000);
        irq_is(1'b0);
    endtask

    task automatic results;
        $display("Comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // The tests take about two hundred cycles; this bound leaves wide margin.
    initial begin
        #200us;
        num_errors++;
        results;
    end

    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_reset;
        t_illegal;
        t_depth;
        t_retry;
        t_irq;
        results;
    end
endmodule // port_error_interrupt_status_tb_top
